// >>> otg_line_sync.sv
// Two-stage synchroniser for the OTG line and comparator indicators
`timescale 1ns/10ps
module otg_line_sync (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [6:0] async_i,
    output logic [6:0] sync_o
);

    // ============================================================
    // One two-flop chain per indicator
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_bit
            logic meta;  // First stage, read only by the second
            // Stage flops reset to a constant
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta <= 1'b0;
                    sync_o[g] <= 1'b0;
                end else begin
                    meta <= async_i[g];
                    sync_o[g] <= meta;
                end
            end
        end
    endgenerate

endmodule : otg_line_sync

// >>> otg_peer_model.sv
// Cable, peer device and VBUS comparator model driving the line indicators
`timescale 1ns/10ps
module otg_peer_model (
    input wire logic mclk_i,
    output usb_otg_pkg::otg_line_t line_o
);
    import usb_otg_pkg::*;

    // ============================================================
    // Idle: no cable, J state on the line, VBUS off
    initial line_o = 7'b1010010;

    // Flip one indicator just after an edge; wake activity is a short pulse
    task automatic kick(input int idx);
        @(posedge mclk_i);
        line_o[idx] <= ~line_o[idx];
        if (idx == 3) begin
            repeat (4) @(posedge mclk_i);
            line_o[3] <= 1'b0;
        end
    endtask : kick

    // Move several indicators at once, as a plug-in does
    task automatic set_all(input logic [6:0] v);
        @(posedge mclk_i);
        line_o <= v;
    endtask : set_all
endmodule : otg_peer_model

// >>> usb_otg_defines.svh
// Offsets, field positions, reset values and timing counts of the OTG enable/status block
`ifndef USB_OTG_DEFINES_SVH
`define USB_OTG_DEFINES_SVH

// ============================================================
// Register byte offsets
`define OTG_FLAGS_OFFSET 8'h00
`define OTG_ENABLES_OFFSET 8'h04
`define OTG_STATUS_OFFSET 8'h08

// ============================================================
// Field positions, shared by flags, enables and status
`define OTG_BIT_ID 7
`define OTG_BIT_TIMER 6
`define OTG_BIT_LINE 5
`define OTG_BIT_ACTIVITY 4
`define OTG_BIT_SESSION 3
`define OTG_BIT_B_END 2
`define OTG_BIT_A_VBUS 0

// Implemented bits of flags and enables
`define OTG_IRQ_MASK 8'hFD
// Implemented bits of the status register
`define OTG_STATUS_MASK 8'hAD

// ============================================================
// Reset values
`define OTG_ENABLES_RESET 8'h00
`define OTG_FLAGS_RESET 8'h00
`define OTG_STATUS_RESET 8'h00

// ============================================================
// AXI response codes
`define OTG_RESP_OKAY 2'h0
`define OTG_RESP_DECERR 2'h3

// ============================================================
// Timing: one millisecond at the 20 ns bus clock, rounded up
`define OTG_CLK_PERIOD_NS 20
`define OTG_MS_NS 1000000
`define OTG_MS_CYCLES ((`OTG_MS_NS + `OTG_CLK_PERIOD_NS - 1) / `OTG_CLK_PERIOD_NS)

`endif

// >>> usb_otg_irq_enable_status.sv
// OTG interrupt flags, enables and live line/VBUS status behind an AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "usb_otg_defines.svh"

module usb_otg_irq_enable_status #(
    parameter int MS_CYCLES = `OTG_MS_CYCLES  // Cycles in one millisecond
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Line and comparator indicators
    input wire usb_otg_pkg::otg_line_t line_i,
    // Level interrupt request
    output logic otg_irq_o
);
    import usb_otg_pkg::*;

    // ============================================================
    // Declarations
    otg_line_t line_s;            // Synchronised indicators
    otg_line_t line_d;            // Previous synchronised values
    logic [7:0] enables;          // Software interrupt enables
    logic [7:0] flags;            // Sticky event flags
    logic [7:0] set_flags;        // Events seen this cycle
    logic [7:0] clr_flags;        // Clears requested this cycle
    logic [7:0] status_byte;      // Live status image
    logic [15:0] ms_count;        // Free-running millisecond divider
    logic ms_tick;                // One-cycle pulse each millisecond
    logic [15:0] line_count;      // Cycles the line state has held
    logic [1:0] line_prev;        // Line state one cycle ago
    logic [1:0] line_last_stable; // Last line state recorded as stable
    logic line_stable_status;     // Held for at least one millisecond
    logic line_stable_hit;        // Pulse when the hold first completes
    logic [2:0] sync_fill;        // Ones shifted in while the synchroniser fills
    logic edges_live;             // Both line_s and line_d carry real pin levels
    logic aw_held;                // Write address captured
    logic w_held;                 // Write data captured
    logic [7:0] aw_addr;          // Captured write address
    logic [7:0] w_byte;           // Captured low data byte
    logic w_lane0;                // Captured strobe of lane 0
    logic do_write;               // Both halves present, response free
    logic ar_take;                // Read address handshake
    otg_read_t next_read;         // Decoded read answer

    // ============================================================
    // Synchronisers
    // two-flop synchronisers
    otg_line_sync u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i(line_i),
        .sync_o(line_s)
    );

    // Previous values for change detection, taken from synchronised side only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_d <= '0;
        end else begin
            line_d <= line_s;
        end
    end

    // Start-up guard for the change detectors
    // Synchroniser and delay stage reset to zero while idle pins may sit high,
    // so without it the first real level would pass for an ID or VBUS change
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_fill <= 3'h0;
        end else begin
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    assign edges_live = sync_fill[2];

    // ============================================================
    // Millisecond timer
    // Free-running so the timer event is periodic regardless of line activity
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ms_count <= 16'h0000;
        end else if (ms_count == 16'(MS_CYCLES - 1)) begin
            ms_count <= 16'h0000;
        end else begin
            ms_count <= ms_count + 16'h0001;
        end
    end

    assign ms_tick = (ms_count == 16'(MS_CYCLES - 1));

    // ============================================================
    // Line-state stability watch
    // count cycles the line holds
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_prev <= 2'h0;
            line_count <= 16'h0000;
            line_stable_status <= 1'b0;
        end else begin
            line_prev <= {line_s.se0, line_s.j_line_indicator};
            if ({line_s.se0, line_s.j_line_indicator} != line_prev) begin
                // Any movement restarts the window
                line_count <= 16'h0000;
                line_stable_status <= 1'b0;
            end else if (line_count == 16'(MS_CYCLES - 1)) begin
                // Saturate; status stays up while the line holds
                line_stable_status <= 1'b1;
            end else begin
                line_count <= line_count + 16'h0001;
            end
        end
    end

    // First cycle the millisecond hold completes
    assign line_stable_hit = !line_stable_status
        && ({line_s.se0, line_s.j_line_indicator} == line_prev)
        && (line_count == 16'(MS_CYCLES - 1));

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_last_stable <= 2'h0;
        end else if (line_stable_hit) begin
            line_last_stable <= line_prev;
        end
    end

    // ============================================================
    // Event detection
    // hardware set sources
    always_comb begin
        set_flags = 8'h00;
        // Either direction of the ID pin is a change
        set_flags[`OTG_BIT_ID] = edges_live && (line_s.cable_id ^ line_d.cable_id);
        set_flags[`OTG_BIT_TIMER] = ms_tick;
        // only a stable state unlike the last
        set_flags[`OTG_BIT_LINE] = line_stable_hit && (line_prev != line_last_stable);
        // Activity is a wake request, so rising edge only
        set_flags[`OTG_BIT_ACTIVITY] = edges_live && line_s.bus_activity && !line_d.bus_activity;
        set_flags[`OTG_BIT_SESSION] = edges_live && (line_s.session_valid ^ line_d.session_valid);
        set_flags[`OTG_BIT_B_END] = edges_live && (line_s.b_session_end ^ line_d.b_session_end);
        set_flags[`OTG_BIT_A_VBUS] = edges_live && (line_s.a_vbus_valid ^ line_d.a_vbus_valid);
    end

    // ============================================================
    // Live status image
    always_comb begin
        status_byte = `OTG_STATUS_RESET;
        status_byte[`OTG_BIT_ID] = line_s.cable_id;
        status_byte[`OTG_BIT_LINE] = line_stable_status;
        status_byte[`OTG_BIT_SESSION] = line_s.session_valid;
        status_byte[`OTG_BIT_B_END] = line_s.b_session_end;
        status_byte[`OTG_BIT_A_VBUS] = line_s.a_vbus_valid;
    end

    // ============================================================
    // AXI write channel capture
    // Address and data may arrive in either order; each is held until both meet
    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;

    // Address half
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Data half; upper lanes are dropped since bits 31..8 do not exist
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata_i[7:0];
            w_lane0 <= s_axi_wstrb_i[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response, one cycle after both halves meet
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `OTG_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            if (aw_addr == `OTG_FLAGS_OFFSET) begin
                s_axi_bresp_o <= `OTG_RESP_OKAY;
            end else if (aw_addr == `OTG_ENABLES_OFFSET) begin
                s_axi_bresp_o <= `OTG_RESP_OKAY;
            end else if (aw_addr == `OTG_STATUS_OFFSET) begin
                s_axi_bresp_o <= `OTG_RESP_OKAY;
            end else begin
                s_axi_bresp_o <= `OTG_RESP_DECERR;
            end
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ============================================================
    // Enable register
    // bit 7 stored
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            enables <= `OTG_ENABLES_RESET;
        end else if (do_write && w_lane0 && aw_addr == `OTG_ENABLES_OFFSET) begin
            enables <= w_byte & `OTG_IRQ_MASK;
        end
    end

    // ============================================================
    // Flag clearing: write one, or a read of the flag register
    always_comb begin
        clr_flags = 8'h00;
        if (do_write && w_lane0 && aw_addr == `OTG_FLAGS_OFFSET) begin
            clr_flags = w_byte;
        end
        // A read hands the bits to software, so they are cleared too
        if (ar_take && s_axi_araddr_i == `OTG_FLAGS_OFFSET) begin
            clr_flags = 8'hFF;
        end
    end

    // Sticky flags; a same-cycle event beats its clear so none is lost
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flags <= `OTG_FLAGS_RESET;
        end else begin
            flags <= ((flags & ~clr_flags) | set_flags) & `OTG_IRQ_MASK;
        end
    end

    // ============================================================
    // Interrupt output
    // any enabled flag raises request
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            otg_irq_o <= 1'b0;
        end else begin
            otg_irq_o <= |(((flags & ~clr_flags) | set_flags) & enables & `OTG_IRQ_MASK);
        end
    end

    // ============================================================
    // AXI read channel
    // One read at a time; address is refused while an answer waits
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

    // Read decode
    always_comb begin
        next_read.resp = `OTG_RESP_OKAY;
        next_read.data = 32'h00000000;
        if (s_axi_araddr_i == `OTG_FLAGS_OFFSET) begin
            next_read.data[7:0] = flags;
        end else if (s_axi_araddr_i == `OTG_ENABLES_OFFSET) begin
            next_read.data[7:0] = enables;
        end else if (s_axi_araddr_i == `OTG_STATUS_OFFSET) begin
            next_read.data[7:0] = status_byte & `OTG_STATUS_MASK;
        end else begin
            next_read.resp = `OTG_RESP_DECERR;
        end
    end

    // Read answer held until the master takes it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `OTG_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= next_read.data;
            s_axi_rresp_o <= next_read.resp;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule : usb_otg_irq_enable_status

// >>> usb_otg_irq_enable_status_tb.sv
// Self-checking bench for the OTG enable/status block
`timescale 1ns/10ps
module usb_otg_irq_enable_status_tb;
    import usb_otg_pkg::*;
    localparam int MS = 20;  // Shortened millisecond keeps the run brief
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    otg_line_t line;
    int fails = 0;
    int compares = 0;
    int bits [7] = '{7, 6, 5, 4, 3, 2, 0};   // Enable bit under test
    int idxs [7] = '{6, -1, 4, 3, 2, 1, 0};  // Line indicator that fires it

    usb_otg_irq_enable_status #(.MS_CYCLES(MS)) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .line_i(line), .otg_irq_o(irq)
    );
    otg_peer_model peer (.mclk_i(mclk_i), .line_o(line));

    // ============================================================
    // Clock, and the watchdog that cuts a hang short
    initial forever #10 mclk_i = ~mclk_i;
    initial begin
        repeat (3000) @(posedge mclk_i);
        fails++;
        report_and_stop();
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Write: ready sampled at the falling edge, taken at the next rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ga;
        logic gw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge mclk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ga && gw)) begin
            @(negedge mclk_i);
            ga = ga | (awvalid & awready);
            gw = gw | (wvalid & wready);
            @(posedge mclk_i);
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
        end
        do @(negedge mclk_i); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge mclk_i);
        bready <= 1'b0;
    endtask : wr

    // Read: result lands in d and resp
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge mclk_i); while (arready !== 1'b1);
        @(posedge mclk_i);
        arvalid <= 1'b0;
        do @(negedge mclk_i); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        @(posedge mclk_i);
        rready <= 1'b0;
    endtask : rd

    // ============================================================
    // Scenarios
    task automatic t_regs();
        rd(8'h04);
        check("enables reset", d, 32'h0);
        rd(8'h08);
        check("status idle", d, 32'h84);
        rd(8'h00);
        check("no reset edges", d & 32'h8D, 32'h0);
        wr(8'h04, 32'hFFFFFFFF, 4'hF);
        rd(8'h04);
        check("enables mask", d, 32'hFD);
        wr(8'h04, 32'h0, 4'h0);
        rd(8'h04);
        check("enables no strobe", d, 32'hFD);
        wr(8'h08, 32'hFF, 4'hF);
        check("status write resp", resp, 2'h0);
        rd(8'h08);
        check("status read only", d & 32'hDF, 32'h84);
        wr(8'h0C, 32'hFF, 4'hF);
        check("unmapped write", resp, 2'h3);
        rd(8'h0C);
        check("unmapped read", {d[29:0], resp}, 32'h3);
    endtask : t_regs

    // Type-A plug with VBUS up, then back to idle; flags clear on read
    task automatic t_cable();
        peer.set_all(7'b0010101);
        repeat (5) @(posedge mclk_i);
        rd(8'h08);
        check("status plugged", d & 32'hDF, 32'h09);
        rd(8'h00);
        check("flags set", d & 32'h8D, 32'h8D);
        rd(8'h00);
        check("flags read clear", d & 32'h8D, 32'h0);
        peer.set_all(7'b1010010);
        repeat (5) @(posedge mclk_i);
        rd(8'h08);
        check("status unplugged", d & 32'hDF, 32'h84);
    endtask : t_cable

    task automatic t_line();
        rd(8'h08);
        check("line stable", d[5], 1'b1);
        peer.kick(4);
        repeat (4) @(posedge mclk_i);
        rd(8'h08);
        check("line moved", d[5], 1'b0);
    endtask : t_line

    // One event source: masked, then enabled, then cleared by writes
    task automatic t_irq(input int b, input int idx);
        wr(8'h04, 32'h0, 4'hF);
        rd(8'h00);
        if (idx >= 0) peer.kick(idx);
        repeat (MS + 6) @(posedge mclk_i);
        @(negedge mclk_i);
        check("irq masked", irq, 1'b0);
        wr(8'h04, 32'h1 << b, 4'hF);
        @(negedge mclk_i);
        check("irq enabled", irq, 1'b1);
        wr(8'h00, ~(32'h1 << b), 4'hF);
        @(negedge mclk_i);
        check("irq zero write", irq, 1'b1);
        if (b == 6) begin
            wr(8'h00, 32'h1 << b, 4'hF);
            do @(negedge mclk_i); while (irq !== 1'b1);
        end
        wr(8'h00, 32'h1 << b, 4'hF);
        @(negedge mclk_i);
        check("irq cleared", irq, 1'b0);
    endtask : t_irq

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ============================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs();
        t_cable();
        t_line();
        for (int i = 0; i < 7; i++) begin
            t_irq(bits[i], idxs[i]);
        end
        report_and_stop();
    end
endmodule : usb_otg_irq_enable_status_tb

// >>> usb_otg_irq_monitor.sv
// Port-level assertion checker for the OTG enable/status block
`timescale 1ns/10ps
module usb_otg_irq_monitor #(
    parameter int MS_CYCLES = 20  // Cycles in one millisecond
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire usb_otg_pkg::otg_line_t line_i,
    input wire logic otg_irq_o
);
    import usb_otg_pkg::*;
    logic [7:0] ra;         // Address of the read under way
    logic [3:0] line_cnt;   // Edges the whole line vector held still
    logic [3:0] rs;         // That count when the read was taken
    logic [15:0] sj_cnt;    // Edges the two line-state bits held still
    logic [15:0] rsj;       // That count when the read was taken
    otg_line_t prev_line;   // Line vector one edge ago
    otg_line_t rl;          // Line vector when the read was taken
    logic wrote;            // Any write accepted since reset

    // ============================================================
    // Line stability counters, saturating so they never wrap
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_line <= '0;
            line_cnt <= 4'h0;
            sj_cnt <= 16'h0;
        end else begin
            prev_line <= line_i;
            line_cnt <= (line_i != prev_line) ? 4'h0 : line_cnt + {3'h0, line_cnt != 4'hF};
            sj_cnt <= (line_i[5:4] != prev_line[5:4]) ? 16'h0 :
                sj_cnt + {15'h0, sj_cnt != 16'hFFFF};
        end
    end

    // Snapshot at the read-taking edge; synchroniser lag is why counts matter
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ra <= 8'h00;
            rs <= 4'h0;
            rsj <= 16'h0;
            rl <= '0;
            wrote <= 1'b0;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                ra <= s_axi_araddr_i;
                rs <= line_cnt;
                rsj <= sj_cnt;
                rl <= line_i;
            end
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                wrote <= 1'b1;
            end
        end
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    hi_bits_zero_a: assert property ($rose(s_axi_rvalid_o) |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    bit1_zero_a: assert property ($rose(s_axi_rvalid_o) |-> !s_axi_rdata_o[1])
        else $error("bit 1 read not zero");
    stat_gaps_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08
        |-> !s_axi_rdata_o[6] && !s_axi_rdata_o[4]) else $error("status gap bits set");
    stat_id_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08 && rs >= 4'h3
        |-> s_axi_rdata_o[7] == rl.cable_id) else $error("cable id status wrong");
    stat_sess_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08 && rs >= 4'h3
        |-> s_axi_rdata_o[3] == rl.session_valid) else $error("session status wrong");
    stat_bend_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08 && rs >= 4'h3
        |-> s_axi_rdata_o[2] == rl.b_session_end) else $error("session end status wrong");
    stat_avbus_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08 && rs >= 4'h3
        |-> s_axi_rdata_o[0] == rl.a_vbus_valid) else $error("vbus valid status wrong");
    line_stable_a: assert property ($rose(s_axi_rvalid_o) && ra == 8'h08
        && rsj >= MS_CYCLES + 4 |-> s_axi_rdata_o[5]) else $error("line stable not shown");
    irq_quiet_a: assert property (!wrote |-> !otg_irq_o)
        else $error("interrupt with all enables clear");
    unmapped_rd_a: assert property ($rose(s_axi_rvalid_o) && ra != 8'h00 && ra != 8'h04
        && ra != 8'h08 |-> s_axi_rresp_o == 2'h3 && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
endmodule : usb_otg_irq_monitor

bind usb_otg_irq_enable_status usb_otg_irq_monitor #(.MS_CYCLES(MS_CYCLES)) u_monitor (
    .mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .line_i(line_i), .otg_irq_o(otg_irq_o)
);

// >>> usb_otg_pkg.sv
// Types shared by the OTG enable/status block
package usb_otg_pkg;

    // ============================================================
    // Line and VBUS indicators arriving from the transceiver and comparators
    typedef struct packed {
        logic cable_id;          // High: no cable or type-B plug
        logic se0;               // Single-ended-zero line indicator
        logic j_line_indicator;  // J-state line indicator
        logic bus_activity;      // Wake activity on D+, D-, ID or VBUS
        logic session_valid;     // VBUS above session valid, A or B
        logic b_session_end;     // VBUS below session valid, B side
        logic a_vbus_valid;      // VBUS above session valid, A side
    } otg_line_t;

    // ============================================================
    // Read channel result
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } otg_read_t;

endpackage : usb_otg_pkg
